// ==== shared/rms_defs.svh ====
// Constants for the radio mode sequencer.
`ifndef RMS_DEFS_SVH
`define RMS_DEFS_SVH
// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define RMS_ADDR_W        4
`define RMS_OFF_CTRL      4'h0
`define RMS_OFF_CFG       4'h1
`define RMS_OFF_TMR       4'h2
`define RMS_OFF_STATUS    4'h3
// Control word fields (write-one command bits).
`define RMS_CTRL_LAUNCH   0
`define RMS_CTRL_STOP     1
// Configuration word fields.
`define RMS_CFG_IDLE_LP   0
`define RMS_CFG_LP_CHOICE 1
`define RMS_CFG_IDLE_EXIT 2
`define RMS_CFG_TX_EXIT   3
`define RMS_CFG_START_LO  4
`define RMS_CFG_RX_LO     6
`define RMS_CFG_WAIT_LO   9
`define RMS_CFG_PKT_LO    11
`define RMS_CFG_RESET     14'h0000
// Timer word fields.
`define RMS_TMR_FIRST_STEP_LO  0
`define RMS_TMR_SECOND_STEP_LO 2
`define RMS_TMR_FIRST_MUL_LO   4
`define RMS_TMR_SECOND_MUL_LO  12
`define RMS_TMR_RESET      20'h00000
// ----------------------------------------------------------------------------
// Timing: step lengths in ns at a 25 ns clock period
// ----------------------------------------------------------------------------
`define RMS_CLK_NS        25
`define RMS_STEP1_NS      64000
`define RMS_STEP2_NS      4100000
`define RMS_STEP3_NS      262000000
`define RMS_STEP1_CYC     (`RMS_STEP1_NS / `RMS_CLK_NS)
`define RMS_STEP2_CYC     (`RMS_STEP2_NS / `RMS_CLK_NS)
`define RMS_STEP3_CYC     (`RMS_STEP3_NS / `RMS_CLK_NS)
`endif

// ==== shared/rms_pkg.sv ====
// Types for the radio mode sequencer.
package rms_pkg;
  typedef enum logic [2:0] {
    RMS_OFF, RMS_IDLE, RMS_TX, RMS_RX, RMS_PKT, RMS_WAIT_FIFO
  } rms_state_t;
  typedef enum logic [2:0] {
    RMS_MODE_SLEEP, RMS_MODE_STANDBY, RMS_MODE_TX, RMS_MODE_RX,
    RMS_MODE_SYNTH
  } rms_mode_t;
endpackage : rms_pkg

// ==== src/rms_timer_chain.sv ====
// Two chained interval timers producing alternating expiry pulses.
`timescale 1ns/1ps
`include "rms_defs.svh"
module rms_timer_chain
  import rms_pkg::*;
#(
  parameter int STEP1_CYC = `RMS_STEP1_CYC,
  parameter int STEP2_CYC = `RMS_STEP2_CYC,
  parameter int STEP3_CYC = `RMS_STEP3_CYC
) (
  input  wire logic       i_clk,
  input  wire logic       i_nrst,
  input  wire logic       i_restart,
  input  wire logic       i_stop,
  input  wire logic [1:0] i_first_step,
  input  wire logic [7:0] i_first_mul,
  input  wire logic [1:0] i_second_step,
  input  wire logic [7:0] i_second_mul,
  output logic            o_first_event,
  output logic            o_second_event
);
  logic        run_q,   run_d;
  logic        phase_q, phase_d;   // 0: timing first, 1: timing second.
  logic [23:0] pre_q,   pre_d;
  logic [7:0]  mul_q,   mul_d;
  logic        fev_q, fev_d, sev_q, sev_d;
  logic [1:0]  step;
  logic [7:0]  mul_lim;
  logic [23:0] pre_lim;

  assign step    = phase_q ? i_second_step : i_first_step;
  assign mul_lim = phase_q ? i_second_mul : i_first_mul;
  always_comb begin
    case (step)
      2'h1:    pre_lim = 24'(STEP1_CYC - 1);
      2'h2:    pre_lim = 24'(STEP2_CYC - 1);
      default: pre_lim = 24'(STEP3_CYC - 1);
    endcase
  end

  // A disabled or zero-length stage halts the chain, so cycling needs both
  // timers running.
  always_comb begin
    run_d = run_q; phase_d = phase_q; pre_d = pre_q; mul_d = mul_q;
    fev_d = 1'b0; sev_d = 1'b0;
    if (i_stop) begin
      run_d = 1'b0;
    end else if (i_restart) begin
      run_d = 1'b1; phase_d = 1'b0; pre_d = '0; mul_d = '0;
    end else if (run_q) begin
      if (step == 2'h0 || mul_lim == 8'h00) begin
        run_d = 1'b0;
      end else if (pre_q == pre_lim) begin
        pre_d = '0;
        if (mul_q == mul_lim - 8'h01) begin
          mul_d = '0;
          phase_d = ~phase_q;
          fev_d = ~phase_q;
          sev_d = phase_q;
        end else begin
          mul_d = mul_q + 8'h01;
        end
      end else begin
        pre_d = pre_q + 24'h000001;
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_q <= 1'b0; phase_q <= 1'b0; pre_q <= '0; mul_q <= '0;
      fev_q <= 1'b0; sev_q <= 1'b0;
    end else begin
      run_q <= run_d; phase_q <= phase_d; pre_q <= pre_d; mul_q <= mul_d;
      fev_q <= fev_d; sev_q <= sev_d;
    end
  end
  assign o_first_event  = fev_q;
  assign o_second_event = sev_q;
endmodule : rms_timer_chain

// ==== src/rms_sequencer.sv ====
// Radio mode sequencer top: registers, event sync and state machine.
// Functional notes
// - Idle holds standby when idle selector is 0, sleep when 1.
// - Launch routes: 00 low-power choice, 01 rx, 10 tx, 11 tx on level.
// - Low-power choice: 0 goes off at initial mode, 1 goes idle.
// - Mode at launch, sleep or standby, is kept as the initial mode.
// - Idle first timer to tx/rx; tx done to low-power choice/rx.
// - Rx exit code picks target and event; 000 and 111 do nothing.
// - Code 011 with failed check on payload and auto-discard off takes the timeout path.
// - Second timer in rx always goes to low-power choice.
// - Timeout exit: 00 rx restart, 01 tx, 10 low-power, 11 off.
// - Any of three receive timeouts counts as the timeout event.
// - Packet-held exit: off, tx on drained, low-power, synth rx, rx.
// - Two interval timers give events that drive transitions.
// - First timer fires step times multiplier after launch or second.
// - Second timer fires step times multiplier after first.
// - Timer chain runs whatever the state; cycling needs both on.
// - Launch only accepted in sleep or standby.
// - Stop forces the off state at any moment.
// - Idle reacts only to the first timer event.
`timescale 1ns/1ps
`include "rms_defs.svh"
module rms_sequencer
  import rms_pkg::*;
(
  input  wire logic                 I_CLK,
  input  wire logic                 I_NRST,
  input  wire logic [`RMS_ADDR_W-1:0] I_ADDR,
  input  wire logic [31:0]          I_WDATA,
  input  wire logic                 I_WR,
  input  wire logic                 I_RD,
  input  wire logic                 I_CHIP_SLEEP,
  input  wire logic                 I_CHIP_STANDBY,
  input  wire logic                 I_TX_DONE_FLAG,
  input  wire logic                 I_PAYLOAD_COMPLETE_FLAG,
  input  wire logic                 I_CHECK_PASSED_FLAG,
  input  wire logic                 I_CHECK_ENABLED,
  input  wire logic                 I_BAD_CHECK_AUTO_DISCARD,
  input  wire logic                 I_QUEUE_LEVEL_EVENT,
  input  wire logic                 I_QUEUE_DRAINED_EVENT,
  input  wire logic                 I_STRENGTH_EVENT,
  input  wire logic                 I_SYNC_MATCH_EVENT,
  input  wire logic                 I_PREAMBLE_FOUND_EVENT,
  input  wire logic                 I_STRENGTH_WAIT_EXPIRED,
  input  wire logic                 I_PREAMBLE_WAIT_EXPIRED,
  input  wire logic                 I_SYNC_WAIT_EXPIRED,
  input  wire logic                 I_FREQ_CHANGED,
  output logic [31:0]               O_RDATA,
  output logic [2:0]                O_MODE,
  output logic                      O_MODE_VALID,
  output logic                      O_RECEIVER_RERUN_STEP,
  output logic [2:0]                O_STATE
);
  // --------------------------------------------------------------------------
  // Event synchronisers
  // --------------------------------------------------------------------------
  // Event inputs come from the packet engine clock, so each is resynchronised.
  localparam int NEV = 16;
  logic [NEV-1:0] ev_raw, ev_s1_q, ev_s2_q, ev_s3_q, ev_rise;
  assign ev_raw = {I_FREQ_CHANGED, I_CHIP_STANDBY, I_CHIP_SLEEP,
                   I_SYNC_WAIT_EXPIRED, I_PREAMBLE_WAIT_EXPIRED,
                   I_STRENGTH_WAIT_EXPIRED, I_PREAMBLE_FOUND_EVENT,
                   I_SYNC_MATCH_EVENT, I_STRENGTH_EVENT,
                   I_QUEUE_DRAINED_EVENT, I_QUEUE_LEVEL_EVENT,
                   I_BAD_CHECK_AUTO_DISCARD, I_CHECK_ENABLED,
                   I_CHECK_PASSED_FLAG, I_PAYLOAD_COMPLETE_FLAG,
                   I_TX_DONE_FLAG};
  genvar g;
  generate
    for (g = 0; g < NEV; g++) begin : g_sync
      always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
          ev_s1_q[g] <= 1'b0;
          ev_s2_q[g] <= 1'b0;
          ev_s3_q[g] <= 1'b0;
        end else begin
          ev_s1_q[g] <= ev_raw[g];
          ev_s2_q[g] <= ev_s1_q[g];
          ev_s3_q[g] <= ev_s2_q[g];
        end
      end
      assign ev_rise[g] = ev_s2_q[g] & ~ev_s3_q[g];
    end
  endgenerate
  logic e_txd, e_pay, e_crc, e_lvl, e_drn, e_rssi, e_sync, e_pre, e_tmo;
  logic chk_en, auto_disc, in_sleep, in_stby, freq_chg;
  assign e_txd  = ev_rise[0];
  assign e_pay  = ev_rise[1];
  assign e_crc  = ev_rise[2];
  assign chk_en = ev_s2_q[3];
  assign auto_disc = ev_s2_q[4];
  assign e_lvl  = ev_rise[5];
  assign e_drn  = ev_rise[6];
  assign e_rssi = ev_rise[7];
  assign e_sync = ev_rise[8];
  assign e_pre  = ev_rise[9];
  assign e_tmo  = |ev_rise[12:10];
  assign in_sleep = ev_s2_q[13];
  assign in_stby  = ev_s2_q[14];
  assign freq_chg = ev_s2_q[15];

  // --------------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------------
  logic [13:0] cfg_q, cfg_d;
  logic [19:0] tmr_q, tmr_d;
  logic [31:0] rdata_q, rdata_d;
  logic        launch_cmd, stop_cmd;
  logic        init_sleep_q, init_sleep_d;

  assign launch_cmd = I_WR && I_ADDR == `RMS_OFF_CTRL
                      && I_WDATA[`RMS_CTRL_LAUNCH];
  assign stop_cmd   = I_WR && I_ADDR == `RMS_OFF_CTRL
                      && I_WDATA[`RMS_CTRL_STOP];

  logic       cf_idle_lp, cf_lp_choice, cf_idle_exit, cf_tx_exit;
  logic [1:0] cf_start, cf_wait;
  logic [2:0] cf_rx, cf_pkt;
  assign cf_idle_lp   = cfg_q[`RMS_CFG_IDLE_LP];
  assign cf_lp_choice = cfg_q[`RMS_CFG_LP_CHOICE];
  assign cf_idle_exit = cfg_q[`RMS_CFG_IDLE_EXIT];
  assign cf_tx_exit   = cfg_q[`RMS_CFG_TX_EXIT];
  assign cf_start     = cfg_q[`RMS_CFG_START_LO +: 2];
  assign cf_rx        = cfg_q[`RMS_CFG_RX_LO +: 3];
  assign cf_wait      = cfg_q[`RMS_CFG_WAIT_LO +: 2];
  assign cf_pkt       = cfg_q[`RMS_CFG_PKT_LO +: 3];

  rms_state_t state_q, state_d;

  always_comb begin
    cfg_d = cfg_q;
    tmr_d = tmr_q;
    rdata_d = 32'h00000000;
    if (I_WR && I_ADDR == `RMS_OFF_CFG) cfg_d = I_WDATA[13:0];
    if (I_WR && I_ADDR == `RMS_OFF_TMR) tmr_d = I_WDATA[19:0];
    if (I_RD) begin
      case (I_ADDR)
        `RMS_OFF_CFG:    rdata_d = {18'h00000, cfg_q};
        `RMS_OFF_TMR:    rdata_d = {12'h000, tmr_q};
        `RMS_OFF_STATUS: rdata_d = {28'h0000000, init_sleep_q, state_q};
        default:         rdata_d = 32'h00000000;
      endcase
    end
  end

  // --------------------------------------------------------------------------
  // Timer chain
  // --------------------------------------------------------------------------
  logic first_ev, second_ev, launch_ok;
  assign launch_ok = launch_cmd && state_q == RMS_OFF
                     && (in_sleep || in_stby);
  rms_timer_chain u_timers (
    .i_clk      (I_CLK),
    .i_nrst     (I_NRST),
    .i_restart  (launch_ok),
    .i_stop     (stop_cmd),
    .i_first_step   (tmr_q[`RMS_TMR_FIRST_STEP_LO +: 2]),
    .i_first_mul    (tmr_q[`RMS_TMR_FIRST_MUL_LO +: 8]),
    .i_second_step  (tmr_q[`RMS_TMR_SECOND_STEP_LO +: 2]),
    .i_second_mul   (tmr_q[`RMS_TMR_SECOND_MUL_LO +: 8]),
    .o_first_event  (first_ev),
    .o_second_event (second_ev)
  );

  // --------------------------------------------------------------------------
  // Sequencer state machine
  // --------------------------------------------------------------------------
  // The timeout path resolves in the same cycle; the packet-held and queue-wait
  // states are held in the register like the stable ones.
  function automatic rms_state_t lp_target(input logic choice);
    lp_target = choice ? RMS_IDLE : RMS_OFF;
  endfunction

  logic       rerun_q, rerun_d;
  logic [2:0] mode_q, mode_d;
  logic       valid_q, valid_d;
  logic       wait_path;

  always_comb begin
    state_d = state_q;
    init_sleep_d = init_sleep_q;
    rerun_d = 1'b0;
    wait_path = 1'b0;
    case (state_q)
      RMS_OFF: begin
        if (launch_ok) begin
          init_sleep_d = in_sleep;
          case (cf_start)
            2'h0:    state_d = lp_target(cf_lp_choice);
            2'h1:    state_d = RMS_RX;
            2'h2:    state_d = RMS_TX;
            default: state_d = RMS_WAIT_FIFO;
          endcase
        end
      end
      RMS_WAIT_FIFO: if (e_lvl) state_d = RMS_TX;
      RMS_IDLE: begin
        if (first_ev) state_d = cf_idle_exit ? RMS_RX : RMS_TX;
      end
      RMS_TX: begin
        if (e_txd) state_d = cf_tx_exit ? RMS_RX
                                        : lp_target(cf_lp_choice);
      end
      RMS_RX: begin
        if (second_ev) begin
          state_d = lp_target(cf_lp_choice);
        end else begin
          case (cf_rx)
            3'h1: if (e_pay) state_d = RMS_PKT;
            3'h2: if (e_pay) state_d = lp_target(cf_lp_choice);
            3'h3: begin
              if (e_crc) state_d = RMS_PKT;
              else if (e_pay && chk_en && !auto_disc)
                wait_path = 1'b1;
            end
            3'h4: if (e_rssi) state_d = RMS_OFF;
            3'h5: if (e_sync) state_d = RMS_OFF;
            3'h6: if (e_pre) state_d = RMS_OFF;
            default: state_d = state_q;
          endcase
          if (e_tmo) wait_path = 1'b1;
          if (wait_path) begin
            case (cf_wait)
              2'h0: begin
                state_d = RMS_RX;
                rerun_d = 1'b1;
              end
              2'h1:    state_d = RMS_TX;
              2'h2:    state_d = lp_target(cf_lp_choice);
              default: state_d = RMS_OFF;
            endcase
          end
        end
      end
      RMS_PKT: begin
        case (cf_pkt)
          3'h0: state_d = RMS_OFF;
          3'h1: if (e_drn) state_d = RMS_TX;
          3'h2: state_d = lp_target(cf_lp_choice);
          3'h3: if (freq_chg) state_d = RMS_RX;
          3'h4: state_d = RMS_RX;
          default: state_d = state_q;
        endcase
      end
      default: state_d = RMS_OFF;
    endcase
    if (stop_cmd) state_d = RMS_OFF;
  end

  // Chip mode request follows the next state so it lines up with O_STATE.
  always_comb begin
    valid_d = state_d != RMS_OFF;
    case (state_d)
      // The next configuration is used so a write made while idle moves
      // the requested mode in the same cycle as the stored selector.
      RMS_IDLE: mode_d = cfg_d[`RMS_CFG_IDLE_LP] ? RMS_MODE_SLEEP
                                                 : RMS_MODE_STANDBY;
      RMS_TX:   mode_d = RMS_MODE_TX;
      RMS_RX:   mode_d = (state_q == RMS_PKT && cf_pkt == 3'h3)
                         ? RMS_MODE_SYNTH : RMS_MODE_RX;
      RMS_PKT:  mode_d = RMS_MODE_RX;
      default:  mode_d = init_sleep_d ? RMS_MODE_SLEEP
                                      : RMS_MODE_STANDBY;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      state_q      <= RMS_OFF;
      init_sleep_q <= 1'b0;
      cfg_q        <= `RMS_CFG_RESET;
      tmr_q        <= `RMS_TMR_RESET;
      rdata_q      <= 32'h00000000;
      rerun_q      <= 1'b0;
      mode_q       <= RMS_MODE_STANDBY;
      valid_q      <= 1'b0;
    end else begin
      state_q      <= state_d;
      init_sleep_q <= init_sleep_d;
      cfg_q        <= cfg_d;
      tmr_q        <= tmr_d;
      rdata_q      <= rdata_d;
      rerun_q      <= rerun_d;
      mode_q       <= mode_d;
      valid_q      <= valid_d;
    end
  end

  assign O_RDATA               = rdata_q;
  assign O_MODE                = mode_q;
  assign O_MODE_VALID          = valid_q;
  assign O_RECEIVER_RERUN_STEP = rerun_q;
  assign O_STATE               = state_q;

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  property p_stop_off;
    @(posedge I_CLK) disable iff (!I_NRST)
      stop_cmd |=> state_q == RMS_OFF;
  endproperty
  a_stop_off: assert property (p_stop_off)
    else $error("stop did not force off");

  property p_idle_mode;
    @(posedge I_CLK) disable iff (!I_NRST)
      state_q == RMS_IDLE |-> O_MODE == (cf_idle_lp ? 3'(RMS_MODE_SLEEP)
                                        : 3'(RMS_MODE_STANDBY));
  endproperty
  a_idle_mode: assert property (p_idle_mode)
    else $error("idle mode wrong");

  property p_launch_gate;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state_q == RMS_OFF && !launch_ok && !$past(stop_cmd))
        |=> $stable(init_sleep_q);
  endproperty
  a_launch_gate: assert property (p_launch_gate)
    else $error("initial mode changed without launch");

  property p_rx_second;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state_q == RMS_RX && second_ev && !stop_cmd)
        |=> state_q == (cf_lp_choice ? RMS_IDLE : RMS_OFF);
  endproperty
  a_rx_second: assert property (p_rx_second)
    else $error("second timer in rx ignored");

  property p_idle_only_first;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state_q == RMS_IDLE && !first_ev && !stop_cmd)
        |=> state_q == RMS_IDLE;
  endproperty
  a_idle_only_first: assert property (p_idle_only_first)
    else $error("idle left without first timer");

  property p_tx_done;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state_q == RMS_TX && e_txd && cf_tx_exit && !stop_cmd)
        |=> state_q == RMS_RX ##0 O_MODE == 3'(RMS_MODE_RX);
  endproperty
  a_tx_done: assert property (p_tx_done)
    else $error("tx done exit wrong");

  property p_rerun;
    @(posedge I_CLK) disable iff (!I_NRST)
      (state_q == RMS_RX && e_tmo && !second_ev && cf_wait == 2'h0
       && !stop_cmd)
        |=> O_RECEIVER_RERUN_STEP ##1 !O_RECEIVER_RERUN_STEP;
  endproperty
  a_rerun: assert property (p_rerun)
    else $error("receiver rerun pulse wrong");

  property p_off_no_mode;
    @(posedge I_CLK) disable iff (!I_NRST)
      state_q == RMS_OFF |-> !O_MODE_VALID;
  endproperty
  a_off_no_mode: assert property (p_off_no_mode)
    else $error("mode valid while off");
endmodule : rms_sequencer

// ==== tb/rms_radio_model.sv ====
// Behavioural radio: chip low-power levels and packet engine events.
`timescale 1ns/1ps
module rms_radio_model
  import rms_pkg::*;
(
  input  wire logic        i_clk,
  input  wire logic [10:0] i_fire,
  input  wire logic        i_init_sleep,
  input  wire logic [2:0]  i_mode,
  input  wire logic        i_mode_valid,
  output logic [10:0]      o_ev,
  output logic             o_sleep,
  output logic             o_standby
);
  logic [10:0] hold_q = 11'h000;
  // Two-cycle pulses, then low, so no rising edge is lost in sync flops.
  always @(posedge i_clk) begin
    hold_q <= i_fire;
    o_ev   <= i_fire | hold_q;
  end
  // The chip follows the requested mode while the sequencer owns it.
  assign o_sleep   = i_mode_valid ? (i_mode == 3'h0) : i_init_sleep;
  assign o_standby = i_mode_valid ? (i_mode == 3'h1) : !i_init_sleep;
endmodule : rms_radio_model

// ==== tb/rms_sequencer_tb.sv ====
// Self-checking bench for the radio mode sequencer.
`timescale 1ns/1ps
`include "rms_defs.svh"
module rms_sequencer_tb import rms_pkg::*;;
  logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdata;
  logic [10:0] fire = 11'h000, ev;
  logic        init_sleep = 1'b0, chk_en = 1'b0, freq = 1'b0, disc = 1'b0;
  logic        sleep, standby, valid, rerun, rd_q = 1'b0;
  logic [2:0]  mode, state, prev_st = 3'h0;
  int          num_errors = 0, samples_checked = 0;
  int          cycles = 0, seed = 63, reruns = 0, synths = 0, chg_t[$];
  logic [31:0] exp_rd[$];
  logic [2:0]  exp_st[$];
  always #12.5 clk = ~clk;
  rms_radio_model u_radio (.i_clk(clk), .i_fire(fire),
    .i_init_sleep(init_sleep), .i_mode(mode), .i_mode_valid(valid),
    .o_ev(ev), .o_sleep(sleep), .o_standby(standby));
  rms_sequencer u_dut (.I_CLK(clk), .I_NRST(nrst), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .I_CHIP_SLEEP(sleep),
    .I_CHIP_STANDBY(standby), .I_TX_DONE_FLAG(ev[0]),
    .I_PAYLOAD_COMPLETE_FLAG(ev[1]), .I_CHECK_PASSED_FLAG(ev[2]),
    .I_CHECK_ENABLED(chk_en), .I_BAD_CHECK_AUTO_DISCARD(disc),
    .I_QUEUE_LEVEL_EVENT(ev[3]), .I_QUEUE_DRAINED_EVENT(ev[4]),
    .I_STRENGTH_EVENT(ev[5]), .I_SYNC_MATCH_EVENT(ev[6]),
    .I_PREAMBLE_FOUND_EVENT(ev[7]), .I_STRENGTH_WAIT_EXPIRED(ev[8]),
    .I_PREAMBLE_WAIT_EXPIRED(ev[9]), .I_SYNC_WAIT_EXPIRED(ev[10]),
    .I_FREQ_CHANGED(freq), .O_RDATA(rdata), .O_MODE(mode),
    .O_MODE_VALID(valid), .O_RECEIVER_RERUN_STEP(rerun), .O_STATE(state));
  // --------------------------------------------------------------------
  // Checking and bus tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : conclude
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [3:0] a, input logic [31:0] e);
    exp_rd.push_back(e);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
  endtask : rd_reg
  task automatic settle();
    for (int i = 0; i < 12000 && exp_st.size() > 0; i++) @(posedge clk);
    repeat (8) @(posedge clk);
    chk(32'(exp_st.size()), 32'h0);
  endtask : settle
  task automatic step(input int n);
    @(posedge clk);
    fire <= 11'h001 << n;
    @(posedge clk);
    fire <= 11'h000;
    settle();
  endtask : step
  task automatic launch(input logic [13:0] cfg, input logic [2:0] e);
    wr_reg(`RMS_OFF_CFG, 32'(cfg));
    if (e != RMS_OFF) exp_st.push_back(e);
    wr_reg(`RMS_OFF_CTRL, 32'h1);
    settle();
  endtask : launch
  task automatic halt();
    exp_st.push_back(RMS_OFF);
    wr_reg(`RMS_OFF_CTRL, 32'h2);
    settle();
  endtask : halt
  // Field order: pkt, wait, rx, start, then tx, idle exit, lp, idle mode.
  function automatic logic [13:0] cf(logic [2:0] pk, logic [1:0] wt,
    logic [2:0] rx, logic [1:0] st, logic [3:0] lo);
    return {pk, wt, rx, st, lo};
  endfunction : cf
  // --------------------------------------------------------------------
  // Output watcher: any state change must match the oldest note
  // --------------------------------------------------------------------
  always @(posedge clk) begin
    cycles++;
    if (cycles > 60000) begin
      num_errors++;
      conclude();
    end else begin
      rd_q <= rd;
      if (rd_q && exp_rd.size() > 0) chk(rdata, exp_rd.pop_front());
      if (state !== prev_st) begin
        chg_t.push_back(cycles);
        if (exp_st.size() == 0) chk(state, prev_st);
        else chk(state, exp_st.pop_front());
      end
      prev_st <= state;
      if (rerun === 1'b1) reruns++;
      if (mode === 3'(RMS_MODE_SYNTH)) synths++;
    end
  end
  initial begin
    logic [13:0] r;
    int          n;
    int          rx_ev[8] = '{1, 1, 1, 2, 5, 6, 7, 1};
    logic [2:0]  rx_t[8] = '{RMS_RX, RMS_PKT, RMS_IDLE, RMS_PKT,
                             RMS_OFF, RMS_OFF, RMS_OFF, RMS_RX};
    logic [2:0]  wt_t[4] = '{RMS_RX, RMS_TX, RMS_IDLE, RMS_OFF};
    logic [2:0]  st_t[4] = '{RMS_IDLE, RMS_RX, RMS_TX, RMS_WAIT_FIFO};
    logic [2:0]  pk_t[5] = '{RMS_OFF, RMS_PKT, RMS_IDLE, RMS_RX, RMS_RX};
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    chk(state, RMS_OFF);
    chk(mode, RMS_MODE_STANDBY);
    chk(valid, 1'b0);
    r = 14'($random(seed));
    wr_reg(`RMS_OFF_CFG, 32'(r));
    rd_reg(`RMS_OFF_CFG, 32'(r));
    wr_reg(`RMS_OFF_STATUS, 32'hff);
    rd_reg(`RMS_OFF_STATUS, 32'h0);
    rd_reg(4'h7, 32'h0);
    rd_reg(`RMS_OFF_TMR, 32'h0);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      launch(cf(3'h0, 2'h0, 3'h0, 2'(s), 4'h2), st_t[s]);
      if (s == 3) begin
        exp_st.push_back(RMS_TX);
        step(3);
      end
      halt();
    end
    $display("test launch routes done");
    init_sleep <= 1'b1;
    repeat (4) @(posedge clk);
    launch(cf(3'h0, 2'h0, 3'h0, 2'h0, 4'h2), RMS_IDLE);
    chk(mode, RMS_MODE_STANDBY);
    step(1);
    step(0);
    halt();
    chk(mode, RMS_MODE_SLEEP);
    rd_reg(`RMS_OFF_STATUS, 32'h8);
    launch(cf(3'h0, 2'h0, 3'h0, 2'h0, 4'h3), RMS_IDLE);
    chk(mode, RMS_MODE_SLEEP);
    halt();
    init_sleep <= 1'b0;
    repeat (4) @(posedge clk);
    launch(cf(3'h0, 2'h0, 3'h0, 2'h2, 4'h0), RMS_TX);
    exp_st.push_back(RMS_OFF);
    step(0);
    chk(mode, RMS_MODE_STANDBY);
    launch(cf(3'h0, 2'h0, 3'h0, 2'h2, 4'h8), RMS_TX);
    exp_st.push_back(RMS_RX);
    step(0);
    halt();
    $display("test idle and transmit done");
    for (int c = 0; c < 8; c++) begin
      launch(cf(3'h1, 2'h0, 3'(c), 2'h1, 4'h2), RMS_RX);
      if (rx_t[c] != RMS_RX) exp_st.push_back(rx_t[c]);
      step(rx_ev[c]);
      if (rx_t[c] != RMS_OFF) halt();
    end
    for (int w = 0; w < 4; w++) begin
      n = reruns;
      launch(cf(3'h0, 2'(w), 3'h0, 2'h1, 4'h2), RMS_RX);
      if (wt_t[w] != RMS_RX) exp_st.push_back(wt_t[w]);
      step(8 + w % 3);
      if (w == 0) chk(32'(reruns - n), 32'h1);
      if (wt_t[w] != RMS_OFF) halt();
    end
    chk_en <= 1'b1;
    launch(cf(3'h0, 2'h1, 3'h3, 2'h1, 4'h2), RMS_RX);
    exp_st.push_back(RMS_TX);
    step(1);
    halt();
    disc <= 1'b1;
    launch(cf(3'h0, 2'h1, 3'h3, 2'h1, 4'h2), RMS_RX);
    step(1);
    halt();
    disc   <= 1'b0;
    chk_en <= 1'b0;
    freq   <= 1'b1;
    for (int p = 0; p < 5; p++) begin
      launch(cf(3'(p), 2'h0, 3'h1, 2'h1, 4'h2), RMS_RX);
      exp_st.push_back(RMS_PKT);
      if (pk_t[p] != RMS_PKT) exp_st.push_back(pk_t[p]);
      step(1);
      if (p == 1) begin
        exp_st.push_back(RMS_TX);
        step(4);
      end
      if (pk_t[p] != RMS_OFF) halt();
    end
    chk(32'(synths), 32'h1);
    $display("test receive exits done");
    wr_reg(`RMS_OFF_TMR, 32'h2015);
    rd_reg(`RMS_OFF_TMR, 32'h2015);
    chg_t.delete();
    exp_st = '{RMS_IDLE, RMS_RX, RMS_IDLE, RMS_RX};
    launch(cf(3'h0, 2'h0, 3'h0, 2'h0, 4'h6), RMS_OFF);
    chk(32'(chg_t[2] - chg_t[1]), 32'd5120);
    chk(32'(chg_t[3] - chg_t[2]), 32'd2560);
    halt();
    wr_reg(`RMS_OFF_TMR, 32'h0);
    $display("test timers done");
    conclude();
  end
endmodule : rms_sequencer_tb
